// File: design/pea_core_regs.vh
// Register map, field positions, reset values and command codes of the
// processing-element command block.
// Assumes a 32-bit Avalon-MM master that uses byte addresses.
//
// Notes on behaviour
// - Enable is cleared, set, inverted, loaded from bit or carry, or ANDed with a test.
// - Bit tests AND enable with all masked memory bits being one, or all zero.
// - Enable stores copy enable into carry, or write, OR or AND it into a bit.
// - Enable stores write at every element, whatever the enable flag holds.
// - Tree operands are signed; memory operands are signed or unsigned per command.
// - Destination and first source share one length; second source has its own.
// - With equal lengths, overflow out of the top byte is dropped.
// - Longer destination: carry ripples through it, short source zero or sign extended.
// - Shorter destination: source bytes above its length are ignored.
// - Results reach memory only where enable was one before the command.
// - Carry need be right only at enabled elements.
// - S register updates at every element, from a memory byte or tree byte.
// - Shifts move by one or four bits; arithmetic right shifts copy the sign.
// - Rotates move one bit through carry, in from carry and out to carry.
// - Merge takes source bits where mask is one, keeps destination bits elsewhere.
// - Tree operand is the low length bytes of the floored expression result.
`ifndef PEA_CORE_REGS_VH
`define PEA_CORE_REGS_VH

// ==========================================================================
// Register byte offsets and read masks.
`define PEA_CMD_OFF   12'h000
`define PEA_OPA_OFF   12'h004
`define PEA_OPB_OFF   12'h008
`define PEA_ARG_OFF   12'h00c
`define PEA_TGT_OFF   12'h010
`define PEA_SELF_OFF  12'h014
`define PEA_TRL_OFF   12'h018
`define PEA_TRH_OFF   12'h01c
`define PEA_STAT_OFF  12'h020
`define PEA_OPA_MASK  32'h01ff_01ff
`define PEA_OPB_MASK  32'h0f0f_01ff
`define PEA_ARG_MASK  32'h0000_07ff
`define PEA_RST_WORD  32'h0000_0000

// ==========================================================================
// Field positions.
`define PEA_DST_LSB   0
`define PEA_SRC0_LSB  16
`define PEA_SRC1_LSB  0
`define PEA_DLEN_LSB  16
`define PEA_SLEN_LSB  24
`define PEA_BYTE_LSB  0
`define PEA_BIT_LSB   8
`define PEA_ST_EN     0
`define PEA_ST_CY     1

// ==========================================================================
// Command codes.
`define PEA_OP_CLR_EN   6'h00
`define PEA_OP_SET_EN   6'h01
`define PEA_OP_INV_EN   6'h02
`define PEA_OP_EN_AT    6'h03
`define PEA_OP_AND_AT   6'h04
`define PEA_OP_EN_BIT   6'h05
`define PEA_OP_EN_CY    6'h06
`define PEA_OP_TST_HI   6'h07
`define PEA_OP_TST_LO   6'h08
`define PEA_OP_EQ_ZERO  6'h09
`define PEA_OP_EQ_ONES  6'h0a
`define PEA_OP_EQ_MEM   6'h0b
`define PEA_OP_GE_MEM   6'h0c
`define PEA_OP_GT_MEM   6'h0d
`define PEA_OP_EQ_TREE  6'h0e
`define PEA_OP_LT_TREE  6'h0f
`define PEA_OP_EN2CY    6'h10
`define PEA_OP_EN2BIT   6'h11
`define PEA_OP_ORBIT    6'h12
`define PEA_OP_ANDBIT   6'h13
`define PEA_OP_ADD_U    6'h14
`define PEA_OP_ADD_S    6'h15
`define PEA_OP_SUB_U    6'h16
`define PEA_OP_SUB_S    6'h17
`define PEA_OP_ADD_TR   6'h18
`define PEA_OP_AND      6'h19
`define PEA_OP_OR       6'h1a
`define PEA_OP_XOR      6'h1b
`define PEA_OP_COPY     6'h1c
`define PEA_OP_TR2MEM   6'h1d
`define PEA_OP_LSL      6'h1e
`define PEA_OP_LSL4     6'h1f
`define PEA_OP_LSR      6'h20
`define PEA_OP_LSR4     6'h21
`define PEA_OP_ASR      6'h22
`define PEA_OP_ASR4     6'h23
`define PEA_OP_ROL      6'h24
`define PEA_OP_ROR      6'h25
`define PEA_OP_MERGE    6'h26
`define PEA_OP_S_MEM    6'h27
`define PEA_OP_S_TREE   6'h28

`endif

// File: design/pea_core.v
// One SIMD processing element: enable flag, carry, S register, pixel
// memory and a byte-serial ALU run by broadcast commands.
// Assumes an Avalon-MM master; commands are written to the command word.
`timescale 1ns/1ps
`include "pea_core_regs.vh"

module pea_core #(
    parameter MEM_BYTES = 384                    // Pixel memory size.
) (
    input  wire        clk_i,                    // System clock.
    input  wire        resetn_i,                 // Reset, active low.
    input  wire [11:0] avs_address_i,            // Byte address.
    input  wire        avs_read_i,               // Read request.
    input  wire        avs_write_i,              // Write request.
    input  wire [31:0] avs_writedata_i,          // Write data.
    input  wire [3:0]  avs_byteenable_i,         // Byte lanes.
    output reg  [31:0] avs_readdata_o,           // Read data.
    output wire        avs_waitrequest_o,        // Stall.
    output wire        enable_o,                 // Enable flag.
    output wire        carry_o,                  // Carry flag.
    output wire [7:0]  s_reg_o,                  // S register.
    output wire        busy_o                    // Command running.
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam [9:0] MEM_TOP = MEM_BYTES[9:0];

    // ======================================================================
    // Reset release.
    reg [1:0] rst_sync_r;
    wire      rst_n;

    // Reset asserts at once and releases two edges later.
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    function [31:0] bmerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            bmerge = old;
            for (k = 0; k < 4; k = k + 1)
                if (be[k])
                    bmerge[8*k +: 8] = nw[8*k +: 8];
        end
    endfunction

    // ======================================================================
    // State.
    reg  [7:0]  mem_r [0:MEM_BYTES-1];
    reg  [5:0]  op_r;
    reg  [31:0] opa_r;
    reg  [31:0] opb_r;
    reg  [31:0] arg_r;
    reg  [31:0] tgt_r;
    reg  [31:0] self_r;
    reg  [63:0] tree_r;
    reg         en_r;
    reg         cy_r;
    reg  [7:0]  s_r;
    reg         state_r;
    reg  [2:0]  idx_r;
    reg         ens_r;
    reg         ch_r;
    reg         zf_r;
    reg  [7:0]  sh_r;
    reg         ack_r;
    reg  [31:0] rd_mux;
    reg         wr_en;
    reg  [8:0]  wr_ad;
    reg  [7:0]  wr_d;
    reg  [7:0]  b_raw;
    reg  [7:0]  fill;
    reg  [7:0]  res;
    reg         cond;

    wire        busy    = (state_r == ST_RUN);
    wire [8:0]  dst     = opa_r[`PEA_DST_LSB +: 9];
    wire [8:0]  src0    = opa_r[`PEA_SRC0_LSB +: 9];
    wire [8:0]  src1    = opb_r[`PEA_SRC1_LSB +: 9];
    wire [3:0]  dlen    = opb_r[`PEA_DLEN_LSB +: 4];
    wire [3:0]  slen    = opb_r[`PEA_SLEN_LSB +: 4];
    wire [7:0]  bdata   = arg_r[`PEA_BYTE_LSB +: 8];
    wire [2:0]  bitsel  = arg_r[`PEA_BIT_LSB +: 3];

    // ======================================================================
    // Avalon slave: one wait state, longer for writes and memory reads while a command runs.
    wire        req     = avs_read_i | avs_write_i;
    wire        is_mem  = avs_address_i[11];
    wire [8:0]  mem_idx = avs_address_i[10:2];
    wire        in_mem  = ({1'b0, mem_idx} < MEM_TOP);
    wire        ok      = ~busy | (avs_read_i & ~is_mem);
    wire        bus_wr  = avs_write_i & ack_r;

    assign avs_waitrequest_o = req & ~ack_r;
    assign enable_o = en_r;
    assign carry_o  = cy_r;
    assign s_reg_o  = s_r;
    assign busy_o   = busy;

    // Read mux; status may be read while busy, memory may not.
    always @* begin
        rd_mux = `PEA_RST_WORD;
        if (is_mem) begin
            if (in_mem)
                rd_mux = {24'h00_0000, mem_r[mem_idx]};
        end else begin
            case (avs_address_i)
                `PEA_CMD_OFF:  rd_mux = {26'h000_0000, op_r};
                `PEA_OPA_OFF:  rd_mux = opa_r & `PEA_OPA_MASK;
                `PEA_OPB_OFF:  rd_mux = opb_r & `PEA_OPB_MASK;
                `PEA_ARG_OFF:  rd_mux = arg_r & `PEA_ARG_MASK;
                `PEA_TGT_OFF:  rd_mux = tgt_r;
                `PEA_SELF_OFF: rd_mux = self_r;
                `PEA_TRL_OFF:  rd_mux = tree_r[31:0];
                `PEA_TRH_OFF:  rd_mux = tree_r[63:32];
                `PEA_STAT_OFF: rd_mux = {16'h0000, s_r, 5'b00000, busy, cy_r, en_r};
                default:       rd_mux = `PEA_RST_WORD;
            endcase
        end
    end

    // Acknowledge and read capture share one edge so data stands with it.
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_r          <= 1'b0;
            avs_readdata_o <= `PEA_RST_WORD;
        end else begin
            ack_r <= req & ~ack_r & ok;
            if (avs_read_i & ~ack_r & ok)
                avs_readdata_o <= rd_mux;
        end
    end

    // ======================================================================
    // Byte-serial datapath.
    wire single = (op_r < `PEA_OP_EQ_ZERO) ||
                  (op_r > `PEA_OP_LT_TREE && op_r < `PEA_OP_ADD_U) ||
                  (op_r > `PEA_OP_ROR);
    wire [2:0] lenm1 = dlen[2:0] - 3'd1;
    wire [2:0] last_idx = single ? 3'd0 : lenm1;
    wire       last = (idx_r == last_idx);
    wire       down = (op_r >= `PEA_OP_LSR && op_r <= `PEA_OP_ASR4) ||
                      (op_r == `PEA_OP_ROR);
    // Right shifts walk from the top byte; a source byte is always read
    // in the cycle its destination byte is written, so aligned overlap is safe.
    wire [2:0] p = down ? (lenm1 - idx_r) : idx_r;
    // Addresses wrap at nine bits; partitions are the issuer's concern.
    wire [8:0] a_ad = src0 + {6'b000000, p};
    wire [8:0] b_ad = src1 + {6'b000000, p};
    wire [8:0] d_ad = dst + {6'b000000, p};
    wire [8:0] t_ad = src1 + {5'b00000, slen} - 9'd1;
    wire [7:0] a_b  = mem_r[a_ad];
    wire [7:0] d_b  = mem_r[dst];
    wire       sgn1 = (op_r == `PEA_OP_ADD_S || op_r == `PEA_OP_SUB_S) &
                      mem_r[t_ad][7];
    // Bytes at or above the second length are extension, never read.
    wire [7:0] m1_b = ({1'b0, p} < slen) ? mem_r[b_ad] : {8{sgn1}};
    wire [7:0] t_b  = tree_r[{p, 3'b000} +: 8];
    wire       sub  = (op_r >= `PEA_OP_EQ_ZERO && op_r <= `PEA_OP_LT_TREE) ||
                      op_r == `PEA_OP_SUB_U || op_r == `PEA_OP_SUB_S;
    wire [7:0] bx   = sub ? ~b_raw : b_raw;
    wire       ci   = (idx_r == 3'd0) ? sub : ch_r;
    wire [8:0] sum  = {1'b0, a_b} + {1'b0, bx} + {8'h00, ci};
    wire       z_now = ((idx_r == 3'd0) | zf_r) & (a_b == b_raw);
    // Signed less-than from the top byte of a - b.
    wire       ovf  = (a_b[7] == bx[7]) & (sum[7] != a_b[7]);
    wire       lt_s = sum[7] ^ ovf;
    wire [7:0] in_b = (idx_r == 3'd0) ? fill : sh_r;
    wire       bitv = d_b[bitsel];
    wire       at_me = (self_r == tgt_r);

    // Second operand and shift fill select.
    always @* begin
        case (op_r)
            `PEA_OP_EQ_ZERO: b_raw = 8'h00;
            `PEA_OP_EQ_ONES: b_raw = 8'hff;
            `PEA_OP_EQ_TREE,
            `PEA_OP_LT_TREE,
            `PEA_OP_ADD_TR:  b_raw = t_b;
            default:         b_raw = m1_b;
        endcase
        case (op_r)
            `PEA_OP_ASR,
            `PEA_OP_ASR4: fill = {8{a_b[7]}};
            `PEA_OP_ROL:  fill = {cy_r, 7'b0000000};
            `PEA_OP_ROR:  fill = {7'b0000000, cy_r};
            default:      fill = 8'h00;
        endcase
    end

    // Result byte; the carry out of the top byte is not stored.
    always @* begin
        case (op_r)
            `PEA_OP_ADD_U, `PEA_OP_ADD_S, `PEA_OP_SUB_U,
            `PEA_OP_SUB_S, `PEA_OP_ADD_TR: res = sum[7:0];
            `PEA_OP_AND:    res = a_b & b_raw;
            `PEA_OP_OR:     res = a_b | b_raw;
            `PEA_OP_XOR:    res = a_b ^ b_raw;
            `PEA_OP_TR2MEM: res = t_b;
            `PEA_OP_LSL, `PEA_OP_ROL: res = {a_b[6:0], in_b[7]};
            `PEA_OP_LSL4:   res = {a_b[3:0], in_b[7:4]};
            `PEA_OP_LSR, `PEA_OP_ASR,
            `PEA_OP_ROR:    res = {in_b[0], a_b[7:1]};
            `PEA_OP_LSR4, `PEA_OP_ASR4: res = {in_b[3:0], a_b[7:4]};
            `PEA_OP_MERGE:  res = (d_b & ~bdata) | (a_b & bdata);
            default:        res = a_b;
        endcase
    end

    // Test outcome that multi-byte and bit tests AND into enable.
    always @* begin
        case (op_r)
            `PEA_OP_TST_HI:  cond = ((a_b & bdata) == bdata);
            `PEA_OP_TST_LO:  cond = ((~a_b & bdata) == bdata);
            `PEA_OP_GE_MEM:  cond = sum[8];
            `PEA_OP_GT_MEM:  cond = sum[8] & ~z_now;
            `PEA_OP_LT_TREE: cond = lt_s;
            default:         cond = z_now;
        endcase
    end

    // ======================================================================
    // Memory write port: commands while busy, the bus otherwise.
    always @* begin
        wr_en = 1'b0;
        wr_ad = dst;
        wr_d  = res;
        if (busy) begin
            case (op_r)
                `PEA_OP_EN2BIT: begin
                    wr_en = 1'b1;
                    wr_d  = d_b;
                    wr_d[bitsel] = en_r;
                end
                `PEA_OP_ORBIT: begin
                    wr_en = 1'b1;
                    wr_d  = d_b;
                    wr_d[bitsel] = bitv | en_r;
                end
                `PEA_OP_ANDBIT: begin
                    wr_en = 1'b1;
                    wr_d  = d_b;
                    wr_d[bitsel] = bitv & en_r;
                end
                `PEA_OP_MERGE:
                    wr_en = ens_r;
                default: begin
                    wr_en = ens_r & (op_r >= `PEA_OP_ADD_U) &
                            (op_r <= `PEA_OP_ROR);
                    wr_ad = d_ad;
                end
            endcase
        end else if (bus_wr & is_mem & in_mem & avs_byteenable_i[0]) begin
            wr_en = 1'b1;
            wr_ad = mem_idx;
            wr_d  = avs_writedata_i[7:0];
        end
    end

    // Pixel memory holds no reset value.
    always @(posedge clk_i) begin
        if (wr_en)
            mem_r[wr_ad] <= wr_d;
    end

    // ======================================================================
    // Control registers, command sequencing and flags.
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            op_r    <= 6'h00;
            opa_r   <= `PEA_RST_WORD;
            opb_r   <= `PEA_RST_WORD;
            arg_r   <= `PEA_RST_WORD;
            tgt_r   <= `PEA_RST_WORD;
            self_r  <= `PEA_RST_WORD;
            tree_r  <= 64'h0000_0000_0000_0000;
            en_r    <= 1'b0;
            cy_r    <= 1'b0;
            s_r     <= 8'h00;
            state_r <= ST_IDLE;
            idx_r   <= 3'd0;
            ens_r   <= 1'b0;
            ch_r    <= 1'b0;
            zf_r    <= 1'b0;
            sh_r    <= 8'h00;
        end else begin
            if (bus_wr & ~is_mem) begin
                case (avs_address_i)
                    `PEA_CMD_OFF: begin
                        op_r    <= avs_writedata_i[5:0];
                        state_r <= ST_RUN;
                        idx_r   <= 3'd0;
                        ens_r   <= en_r;
                    end
                    `PEA_OPA_OFF:  opa_r  <= bmerge(opa_r, avs_writedata_i, avs_byteenable_i);
                    `PEA_OPB_OFF:  opb_r  <= bmerge(opb_r, avs_writedata_i, avs_byteenable_i);
                    `PEA_ARG_OFF:  arg_r  <= bmerge(arg_r, avs_writedata_i, avs_byteenable_i);
                    `PEA_TGT_OFF:  tgt_r  <= bmerge(tgt_r, avs_writedata_i, avs_byteenable_i);
                    `PEA_SELF_OFF: self_r <= bmerge(self_r, avs_writedata_i, avs_byteenable_i);
                    `PEA_TRL_OFF:  tree_r[31:0] <= bmerge(tree_r[31:0], avs_writedata_i,
                                                          avs_byteenable_i);
                    `PEA_TRH_OFF:  tree_r[63:32] <= bmerge(tree_r[63:32], avs_writedata_i,
                                                           avs_byteenable_i);
                    `PEA_STAT_OFF: begin
                        if (avs_byteenable_i[0]) begin
                            en_r <= avs_writedata_i[`PEA_ST_EN];
                            cy_r <= avs_writedata_i[`PEA_ST_CY];
                        end
                    end
                    default: ;
                endcase
            end
            if (busy) begin
                ch_r  <= sum[8];
                zf_r  <= z_now;
                sh_r  <= a_b;
                idx_r <= idx_r + 3'd1;
                if (last) begin
                    state_r <= ST_IDLE;
                    case (op_r)
                        `PEA_OP_CLR_EN: en_r <= 1'b0;
                        `PEA_OP_SET_EN: en_r <= 1'b1;
                        `PEA_OP_INV_EN: en_r <= ~en_r;
                        `PEA_OP_EN_AT:  en_r <= at_me;
                        `PEA_OP_AND_AT: en_r <= en_r & at_me;
                        `PEA_OP_EN_BIT: en_r <= bitv;
                        `PEA_OP_EN_CY:  en_r <= cy_r;
                        `PEA_OP_EN2CY:  cy_r <= en_r;
                        `PEA_OP_S_MEM:  s_r  <= a_b;
                        `PEA_OP_S_TREE: s_r  <= tree_r[7:0];
                        `PEA_OP_ADD_U, `PEA_OP_ADD_S, `PEA_OP_ADD_TR:
                            if (ens_r) cy_r <= sum[8];
                        `PEA_OP_SUB_U, `PEA_OP_SUB_S:
                            if (ens_r) cy_r <= ~sum[8];
                        `PEA_OP_ROL:
                            if (ens_r) cy_r <= a_b[7];
                        `PEA_OP_ROR:
                            if (ens_r) cy_r <= a_b[0];
                        default: begin
                            if (op_r == `PEA_OP_TST_HI || op_r == `PEA_OP_TST_LO ||
                                (op_r >= `PEA_OP_EQ_ZERO && op_r <= `PEA_OP_LT_TREE))
                                en_r <= en_r & cond;
                            if (ens_r && (op_r == `PEA_OP_GE_MEM || op_r == `PEA_OP_GT_MEM ||
                                          op_r == `PEA_OP_LT_TREE))
                                cy_r <= ~sum[8];
                        end
                    endcase
                end
            end
        end
    end

endmodule

// File: sim/pea_core_monitor.sv
// Port-level checks of the processing element's flags and busy timing.
// Assumes a command starts on the completed write to offset zero.
`timescale 1ns/1ps
`include "pea_core_regs.vh"

module pea_core_monitor (
    input wire        clk_i,             // System clock.
    input wire        resetn_i,          // Reset, active low.
    input wire [11:0] avs_address_i,     // Byte address.
    input wire        avs_write_i,       // Write request.
    input wire [31:0] avs_writedata_i,   // Write data.
    input wire        avs_waitrequest_o, // Stall.
    input wire        enable_o,          // Enable flag.
    input wire        carry_o,           // Carry flag.
    input wire [7:0]  s_reg_o,           // S register.
    input wire        busy_o             // Command running.
);
    // ==================================================================
    // Completed writes to the command and status words.
    wire       done_w = avs_write_i && !avs_waitrequest_o;
    wire       go     = done_w && (avs_address_i == `PEA_CMD_OFF);
    wire       stw    = done_w && (avs_address_i == `PEA_STAT_OFF);
    wire [5:0] op     = avs_writedata_i[5:0];

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ==================================================================
    // Flag results must be in place once the element is idle again.
    clr_enable_a: assert property (
        go && op == `PEA_OP_CLR_EN |=> ##[1:4] (!busy_o && !enable_o))
        else $error("enable not cleared");
    set_enable_a: assert property (
        go && op == `PEA_OP_SET_EN |=> ##[1:4] (!busy_o && enable_o))
        else $error("enable not set");
    inv_enable_a: assert property (
        go && op == `PEA_OP_INV_EN && enable_o |=> ##[1:4] (!busy_o && !enable_o))
        else $error("enable not inverted");
    carry_load_a: assert property (
        go && op == `PEA_OP_EN_CY |=> ##[1:4] (!busy_o && enable_o == carry_o))
        else $error("enable not loaded from carry");
    en_to_carry_a: assert property (
        go && op == `PEA_OP_EN2CY && !enable_o |=> ##[1:4] (!busy_o && !carry_o))
        else $error("carry not copied from enable");
    // Flags only move at the end of a command or on a status write.
    en_source_a: assert property (
        $changed(enable_o) |-> $past(busy_o) || $past(stw))
        else $error("enable changed outside a command");
    cy_source_a: assert property (
        $changed(carry_o) |-> $past(busy_o) || $past(stw))
        else $error("carry changed outside a command");
    s_source_a: assert property (
        $changed(s_reg_o) |-> $past(busy_o))
        else $error("S changed outside a command");
    // Eight bytes at most, so busy never outlasts eight cycles.
    busy_len_a: assert property (
        go |=> busy_o ##[1:8] !busy_o)
        else $error("busy length wrong");

    cover property (go && op == `PEA_OP_ADD_U);
    cover property (go && op == `PEA_OP_ROL);
    cover property (stw);
endmodule

bind pea_core pea_core_monitor mon (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .enable_o(enable_o),
    .carry_o(carry_o), .s_reg_o(s_reg_o), .busy_o(busy_o));

// File: sim/pea_seq.sv
// Sequencer model: an Avalon-MM master issuing one access at a time.
// Assumes one clock; a read result is strobed for one cycle.
`timescale 1ns/1ps

module pea_seq (
    input  wire        clk_i,   // System clock.
    input  wire        wait_i,  // Slave stall.
    input  wire [31:0] rdata_i, // Read data.
    output reg  [11:0] addr_o,  // Byte address.
    output reg         read_o,  // Read request.
    output reg         write_o, // Write request.
    output reg  [31:0] wdata_o, // Write data.
    output wire [3:0]  be_o,    // Byte lanes.
    output reg         vld_o,   // Read result strobe.
    output reg  [31:0] data_o   // Captured read data.
);
    assign be_o = 4'hf;
    initial begin
        {addr_o, read_o, write_o, wdata_o, vld_o, data_o} = 79'h0;
    end
    // Holds the request until stall is seen low; request lines drop and address
    // and data are inverted so nothing can lean on stale values.
    task xfer(input w, input [11:0] a, input [31:0] d, output ok);
        integer k;
        begin
            ok = 1'b0;
            @(posedge clk_i);
            addr_o <= a;
            wdata_o <= d;
            write_o <= w;
            read_o <= !w;
            for (k = 0; k < 64 && !ok; k = k + 1) begin
                @(posedge clk_i);
                ok = (wait_i === 1'b0);
            end
            {write_o, read_o} <= 2'h0;
            addr_o <= ~a;
            wdata_o <= ~d;
            data_o <= rdata_i;
            vld_o <= ok && !w;
            // The strobe lasts one cycle, so the watcher sees it once.
            @(posedge clk_i);
            vld_o <= 1'b0;
        end
    endtask
endmodule

// File: sim/simd_pe_enable_and_alu_ops_bench.sv
// Self-checking bench: commands go through the sequencer model, results
// come back as status words and memory bytes. Assumes the shared header.
`timescale 1ns/1ps
`include "pea_core_regs.vh"

module simd_pe_enable_and_alu_ops_bench;
    // ==================================================================
    // Wiring and bookkeeping.
    reg         clk_i = 1'b0;
    reg         resetn_i = 1'b0;
    wire [11:0] adr;
    wire        rd_w, wr_w, wrq, en, cy, bsy, vld;
    wire [31:0] wd, rdat, seen;
    wire [3:0]  be;
    wire [7:0]  s;
    reg  [31:0] q[$];
    reg  [7:0]  m[0:31];
    reg  [16:0] sum;
    reg         ok, e_en, e_cy;
    reg  [7:0]  e_s;
    integer     n_fail = 0;
    integer     samples_checked = 0;
    integer     i;
    localparam [23:0] EOPS = {`PEA_OP_CLR_EN, `PEA_OP_INV_EN, `PEA_OP_INV_EN, `PEA_OP_SET_EN};

    pea_core dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
        .avs_read_i(rd_w), .avs_write_i(wr_w), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
        .enable_o(en), .carry_o(cy), .s_reg_o(s), .busy_o(bsy));
    pea_seq seq (.clk_i(clk_i), .wait_i(wrq), .rdata_i(rdat), .addr_o(adr),
        .read_o(rd_w), .write_o(wr_w), .wdata_o(wd), .be_o(be), .vld_o(vld),
        .data_o(seen));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // ==================================================================
    // Checking and closing.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            if (q.size() != 0) n_fail = n_fail + 1;
            $display("checks %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task tmo;
        begin
            n_fail = n_fail + 1;
            close_out;
        end
    endtask
    // Replies return in issue order, so the oldest note is the match.
    always @(posedge clk_i) begin
        if (vld === 1'b1) chk(seen, q.pop_front());
    end

    // ==================================================================
    // Bus and command helpers.
    task wr(input [11:0] a, input [31:0] d);
        begin
            seq.xfer(1'b1, a, d, ok);
            if (!ok) tmo;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            q.push_back(e);
            seq.xfer(1'b0, a, 32'h0000_0000, ok);
            if (!ok) tmo;
        end
    endtask
    task mw(input [4:0] x, input [7:0] v);
        begin
            m[x] = v;
            wr({1'b1, 4'h0, x, 2'h0}, {24'h00_0000, v});
        end
    endtask
    task mr(input [4:0] x);
        rd({1'b1, 4'h0, x, 2'h0}, {24'h00_0000, m[x]});
    endtask
    task stat;
        begin
            chk({s, bsy, cy, en}, {e_s, 1'b0, e_cy, e_en});
            rd(`PEA_STAT_OFF, {16'h0000, e_s, 6'h00, e_cy, e_en});
        end
    endtask
    // Waits for busy to drop, bounded, after the command word lands.
    task run(input [5:0] op);
        integer k;
        begin
            wr(`PEA_CMD_OFF, {26'h000_0000, op});
            k = 0;
            @(posedge clk_i);
            while (bsy !== 1'b0 && k < 40) begin
                @(posedge clk_i);
                k = k + 1;
            end
            if (k == 40) tmo;
        end
    endtask

    // ==================================================================
    // Main sequence.
    initial begin
        i = $urandom(30291);
        {e_s, e_cy, e_en} = 10'h000;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        stat;
        rd(12'h7f0, 32'h0000_0000);
        for (i = 0; i < 4; i = i + 1) begin
            run(EOPS[6*i +: 6]);
            e_en = ~e_en;
            stat;
        end
        for (i = 0; i < 32; i = i + 1) mw(i[4:0], 8'($urandom));
        wr(`PEA_OPA_OFF, 32'h0000_0010);
        wr(`PEA_OPB_OFF, 32'h0102_0008);
        run(`PEA_OP_ADD_U);
        mr(16);
        mr(17);
        run(`PEA_OP_EN2CY);
        e_cy = e_en;
        wr(`PEA_ARG_OFF, 32'h0000_0300);
        run(`PEA_OP_EN2BIT);
        m[16][3] = e_en;
        mr(16);
        wr(`PEA_OPA_OFF, 32'h0001_0010);
        run(`PEA_OP_S_MEM);
        e_s = m[1];
        stat;
        wr(`PEA_OPA_OFF, 32'h0000_0010);
        run(`PEA_OP_SET_EN);
        e_en = 1'b1;
        run(`PEA_OP_ADD_U);
        sum = {m[1], m[0]} + m[8];
        {e_cy, m[17], m[16]} = sum;
        mr(16);
        mr(17);
        stat;
        run(`PEA_OP_SUB_U);
        sum = {m[1], m[0]} - m[8];
        {e_cy, m[17], m[16]} = sum;
        mr(16);
        mr(17);
        stat;
        wr(`PEA_OPA_OFF, 32'h0010_0018);
        run(`PEA_OP_ROL);
        sum = {m[17], m[16], e_cy};
        {e_cy, m[25], m[24]} = sum;
        mr(24);
        mr(25);
        run(`PEA_OP_EN_CY);
        e_en = e_cy;
        stat;
        repeat (4) @(posedge clk_i);
        close_out;
    end
endmodule
